// ===== src/tsrb_core.sv
// Register bank of a two-zone thermal supervisor, reached by command byte.
//
// Summary of operation
// - Local result read-only at command zero.
// - Temperatures two's complement, one degree per step.
// - Results reset zero, valid after first conversion.
// - Remote high byte read-only at command one.
// - Word read gives high then low, same conversion.
// - Byte read at command one gives high byte.
// - Word reads only for remote high register.
// - Status register at command two, resets zero.
// - Status bit 7 shows data available.
// - Status bits 6..0 map the zone events.
// - Reading status clears every status bit.
// - Setup register read/write at three, resets 80h.
// - Setup bit 7 enables the interrupt output.
// - Setup bit 6 selects shutdown.
// - Fault depth codes give 1, 2, 4, 6.
// - Resolution codes give 9 to 12 bits.
// - Setup bit 0 warm-resets unless lock forbids.
// - Setup write purges queues, restarts conversion.
// - Mask register read/write at four, resets 07h.
// - Mask bits pair one-to-one with status bits.
// - Enabled event sets flag, clears mask bit (bits 7..2 only), interrupts.
// - Shutdown entry drops interrupt, clears status, purges.
// - Low lock bits force interrupt enable on.
// - Shutdown lock holds shutdown at zero.
`timescale 1ns/1ps
module tsrb_core
	import tsrb_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic        lk_clk_i,
	input  wire logic        lk_req_i,
	input  wire logic [7:0]  lk_cmd_i,
	input  wire logic        lk_write_i,
	input  wire logic        lk_word_i,
	input  wire logic [7:0]  lk_wdata_i,
	output logic             lk_busy_o,
	output logic             lk_done_o,
	output logic      [15:0] lk_rdata_o,
	input  wire logic        conv_done_i,
	input  wire logic [7:0]  local_temp_i,
	input  wire logic [7:0]  remote_high_i,
	input  wire logic [7:0]  remote_low_i,
	input  wire logic [7:0]  event_i,
	input  wire logic [4:0]  lock_i,
	output logic             global_interrupt_enable_o,
	output logic             shutdown_select_o,
	output logic      [1:0]  fault_queue_depth_o,
	output logic      [2:0]  fault_queue_count_o,
	output logic      [1:0]  remote_resolution_o,
	output logic             fault_purge_o,
	output logic             conv_restart_o,
	output logic             warm_reset_o,
	output logic             int_pin_o,
	output logic             int_pin_oe_o
);

	// ********************************************************
	// State
	// ********************************************************
	typedef struct packed {
		logic [7:0]  flags;
		logic [7:0]  mask;
		logic        ie;
		logic        shutdown_select;
		logic [1:0]  fq;
		logic [1:0]  res;
		logic        rsv;
		logic [7:0]  local_t;
		logic [7:0]  rhigh;
		logic [7:0]  rlow;
		logic        int_pend;
		logic [15:0] rdata;
		logic        ack_tog;
		logic        req_prev;
		logic        restart;
		logic        purge;
		logic        warm;
	} tsrb_state_t;

	localparam tsrb_state_t RESET_STATE = '{
		flags:    RST_FLAGS,
		mask:     RST_MASK,
		ie:       RST_SETUP[SET_IE],
		shutdown_select:     RST_SETUP[SET_SHUTDOWN_SELECT],
		fq:       RST_SETUP[SET_FQ_LO+1:SET_FQ_LO],
		res:      RST_SETUP[SET_RS_LO+1:SET_RS_LO],
		rsv:      RST_SETUP[SET_RSV],
		local_t:  RST_RESULT,
		rhigh:    RST_RESULT,
		rlow:     RST_RESULT,
		int_pend: 1'b0,
		rdata:    16'h0000,
		ack_tog:  1'b0,
		req_prev: 1'b0,
		restart:  1'b0,
		purge:    1'b0,
		warm:     1'b0
	};

	tsrb_state_t s;
	tsrb_state_t next_s;

	logic        req_tog;
	logic        req_sync;
	logic [7:0]  acc_cmd;
	logic        acc_wr;
	logic        acc_word;
	logic [7:0]  acc_wdata;
	logic        req_hit;
	logic        ie_eff;
	logic [7:0]  setup_rd;
	logic [7:0]  rd_byte;
	logic [7:0]  ev;
	logic        setup_wr;
	logic        raise;
	logic        lock_hit;

	// ********************************************************
	// Link side and crossing
	// ********************************************************
	tsrb_link_port u_link
	(
		.lk_clk_i  (lk_clk_i),
		.rst_i     (rst_i),
		.req_i     (lk_req_i),
		.cmd_i     (lk_cmd_i),
		.write_i   (lk_write_i),
		.word_i    (lk_word_i),
		.wdata_i   (lk_wdata_i),
		.busy_o    (lk_busy_o),
		.done_o    (lk_done_o),
		.rdata_o   (lk_rdata_o),
		.req_tog_o (req_tog),
		.cmd_o     (acc_cmd),
		.write_o   (acc_wr),
		.word_o    (acc_word),
		.wdata_o   (acc_wdata),
		.ack_tog_i (s.ack_tog),
		.rdata_i   (s.rdata)
	);

	tsrb_sync2 #(.W(1)) u_req_sync
	(
		.clk_i (mclk_i),
		.d_i   (req_tog),
		.q_o   (req_sync)
	);

	// ********************************************************
	// Read view
	// ********************************************************
	// The low lock bits pin the interrupt enable, and the readback must
	// show that, so it reads the effective value, not the stored one.
	always_comb
	begin
		ie_eff   = s.ie | (|lock_i[LCK_DIODE:LCK_LOVT]);
		setup_rd = {ie_eff, s.shutdown_select, s.fq, s.res, s.rsv, 1'b0};
		unique case (acc_cmd)
			CMD_LOCAL: rd_byte = s.local_t;
			CMD_RHIGH: rd_byte = s.rhigh;
			CMD_FLAGS: rd_byte = s.flags;
			CMD_SETUP: rd_byte = setup_rd;
			CMD_MASK:  rd_byte = s.mask;
			default:   rd_byte = 8'h00;
		endcase
	end

	// ********************************************************
	// Access decode and event gating
	// ********************************************************
	// A converter that is shut down or being aborted reports nothing.
	// A locked overtemperature or diode event must reach the pin even
	// with the enable or its mask bit cleared, so it bypasses both.
	always_comb
	begin
		req_hit  = req_sync ^ s.req_prev;
		setup_wr = req_hit && acc_wr && (acc_cmd == CMD_SETUP);
		ev       = (s.shutdown_select || setup_wr) ? 8'h00 : event_i;
		lock_hit = 1'b0;
		if (ev[FLG_LOVT] && lock_i[LCK_LOVT])
		begin
			lock_hit = 1'b1;
		end
		if (ev[FLG_ROVT] && lock_i[LCK_ROVT])
		begin
			lock_hit = 1'b1;
		end
		if (ev[FLG_DIODE] && lock_i[LCK_DIODE])
		begin
			lock_hit = 1'b1;
		end
	end

	// ********************************************************
	// Next state
	// ********************************************************
	always_comb
	begin
		next_s          = s;
		next_s.restart  = 1'b0;
		next_s.purge    = 1'b0;
		next_s.warm     = 1'b0;
		next_s.req_prev = req_sync;

		// Results are stored two's complement exactly as converted.
		if (conv_done_i && !s.shutdown_select && !setup_wr)
		begin
			next_s.local_t = local_temp_i;
			next_s.rhigh   = remote_high_i;
			next_s.rlow    = remote_low_i;
		end

		// ---- Host access ----
		if (req_hit)
		begin
			next_s.ack_tog = ~s.ack_tog;
			if (!acc_wr)
			begin
				if (acc_word && acc_cmd == CMD_RHIGH)
				begin
					next_s.rdata = {s.rhigh, s.rlow};
				end
				else
				begin
					next_s.rdata = {rd_byte, 8'h00};
				end
				if (acc_cmd == CMD_FLAGS)
				begin
					next_s.flags    = 8'h00;
					next_s.int_pend = 1'b0;
				end
			end
			else if (acc_cmd == CMD_MASK)
			begin
				next_s.mask = acc_wdata;
			end
			else if (acc_cmd == CMD_SETUP)
			begin
				next_s.ie      = acc_wdata[SET_IE];
				next_s.shutdown_select    = acc_wdata[SET_SHUTDOWN_SELECT];
				next_s.fq      = acc_wdata[SET_FQ_LO+1:SET_FQ_LO];
				next_s.res     = acc_wdata[SET_RS_LO+1:SET_RS_LO];
				next_s.rsv     = acc_wdata[SET_RSV];
				next_s.purge   = 1'b1;
				next_s.restart = 1'b1;
			end
			// Any other write, read-only targets included, changes nothing.
		end

		// ---- Events ----
		// Events are ORed in after the read clear, so a set that meets
		// the clear of the same cycle survives.
		next_s.flags = next_s.flags | ev;
		raise = (ie_eff && (|(ev & s.mask))) || lock_hit;
		if (raise)
		begin
			next_s.int_pend = 1'b1;
		end
		if (ie_eff)
		begin
			next_s.mask = next_s.mask & ~(ev & MASK_SELF_CLR);
		end

		// ---- Locks ----
		if (lock_i[LCK_LOVT])
		begin
			next_s.mask[FLG_LOVT] = 1'b1;
		end
		if (lock_i[LCK_ROVT])
		begin
			next_s.mask[FLG_ROVT] = 1'b1;
		end
		if (lock_i[LCK_DIODE])
		begin
			next_s.mask[FLG_DIODE] = s.mask[FLG_DIODE];
		end
		if (lock_i[LCK_SHUTDOWN_SELECT])
		begin
			next_s.shutdown_select = 1'b0;
		end

		// ---- Shutdown entry ----
		if (next_s.shutdown_select && !s.shutdown_select)
		begin
			next_s.flags    = 8'h00;
			next_s.int_pend = 1'b0;
			next_s.purge    = 1'b1;
		end

		// ---- Warm reset ----
		// The handshake bits survive, otherwise the pending access on
		// the link would never complete.
		if (setup_wr && acc_wdata[SET_WARM] && !lock_i[LCK_WARM])
		begin
			next_s          = RESET_STATE;
			next_s.ack_tog  = ~s.ack_tog;
			next_s.req_prev = req_sync;
			next_s.rdata    = s.rdata;
			next_s.purge    = 1'b1;
			next_s.restart  = 1'b1;
			next_s.warm     = 1'b1;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			s <= RESET_STATE;
		end
		else
		begin
			s <= next_s;
		end
	end

	// ********************************************************
	// Outputs
	// ********************************************************
	always_comb
	begin
		unique case (s.fq)
			2'b00: fault_queue_count_o = FQ_CNT_0;
			2'b01: fault_queue_count_o = FQ_CNT_1;
			2'b10: fault_queue_count_o = FQ_CNT_2;
			2'b11: fault_queue_count_o = FQ_CNT_3;
		endcase
	end

	assign global_interrupt_enable_o = ie_eff;
	assign shutdown_select_o         = s.shutdown_select;
	assign fault_queue_depth_o       = s.fq;
	assign remote_resolution_o       = s.res;
	assign fault_purge_o             = s.purge;
	assign conv_restart_o            = s.restart;
	assign warm_reset_o              = s.warm;
	// Open-drain pin: only ever pulled low.
	assign int_pin_o                 = 1'b0;
	assign int_pin_oe_o              = s.int_pend;

endmodule

// ===== src/tsrb_pkg.sv
// Constants and types shared by the thermal supervisor register bank.
package tsrb_pkg;

	// ********************************************************
	// Command bytes
	// ********************************************************
	localparam logic [7:0] CMD_LOCAL  = 8'h00;
	localparam logic [7:0] CMD_RHIGH  = 8'h01;
	localparam logic [7:0] CMD_FLAGS  = 8'h02;
	localparam logic [7:0] CMD_SETUP  = 8'h03;
	localparam logic [7:0] CMD_MASK   = 8'h04;

	// ********************************************************
	// Values after reset
	// ********************************************************
	localparam logic [7:0] RST_RESULT = 8'h00;
	localparam logic [7:0] RST_FLAGS  = 8'h00;
	localparam logic [7:0] RST_SETUP  = 8'h80;
	localparam logic [7:0] RST_MASK   = 8'h07;

	// ********************************************************
	// Field positions
	// ********************************************************
	localparam int SET_IE    = 7;
	localparam int SET_SHUTDOWN_SELECT  = 6;
	localparam int SET_FQ_LO = 4;
	localparam int SET_RS_LO = 2;
	localparam int SET_RSV   = 1;
	localparam int SET_WARM  = 0;
	localparam int FLG_READY = 7;
	localparam int FLG_DIODE = 2;
	localparam int FLG_ROVT  = 1;
	localparam int FLG_LOVT  = 0;
	localparam int LCK_LOVT  = 0;
	localparam int LCK_ROVT  = 1;
	localparam int LCK_DIODE = 2;
	localparam int LCK_SHUTDOWN_SELECT  = 3;
	localparam int LCK_WARM  = 4;
	localparam logic [7:0] MASK_SELF_CLR = 8'hFC;

	// ********************************************************
	// Fault queue counts per depth code
	// ********************************************************
	localparam logic [2:0] FQ_CNT_0 = 3'h1;
	localparam logic [2:0] FQ_CNT_1 = 3'h2;
	localparam logic [2:0] FQ_CNT_2 = 3'h4;
	localparam logic [2:0] FQ_CNT_3 = 3'h6;

	typedef enum logic {
		LK_IDLE = 1'b0,
		LK_WAIT = 1'b1
	} tsrb_link_st_t;

endpackage

// ===== src/tsrb_sync2.sv
// Two flip-flop level synchroniser for the thermal register bank.
`timescale 1ns/1ps
module tsrb_sync2
	import tsrb_pkg::*;
#(
	parameter int W = 1
)
(
	input  wire logic         clk_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} tsrb_sync_t;

	tsrb_sync_t s;
	tsrb_sync_t next_s;

	// The first stage is read only by the second; no reset, so it is
	// free of any path back into the source domain.
	always_comb
	begin
		next_s    = s;
		next_s.s1 = d_i;
		next_s.s2 = s.s1;
	end

	always_ff @(posedge clk_i)
	begin
		s <= next_s;
	end

	assign q_o = s.s2;

endmodule

// ===== src/tsrb_link_port.sv
// Link-clock side of the register access handshake.
`timescale 1ns/1ps
module tsrb_link_port
	import tsrb_pkg::*;
(
	input  wire logic        lk_clk_i,
	input  wire logic        rst_i,
	input  wire logic        req_i,
	input  wire logic [7:0]  cmd_i,
	input  wire logic        write_i,
	input  wire logic        word_i,
	input  wire logic [7:0]  wdata_i,
	output logic             busy_o,
	output logic             done_o,
	output logic      [15:0] rdata_o,
	output logic             req_tog_o,
	output logic      [7:0]  cmd_o,
	output logic             write_o,
	output logic             word_o,
	output logic      [7:0]  wdata_o,
	input  wire logic        ack_tog_i,
	input  wire logic [15:0] rdata_i
);

	typedef struct packed {
		tsrb_link_st_t st;
		logic          req_tog;
		logic          ack_prev;
		logic [7:0]    cmd;
		logic          wr;
		logic          word;
		logic [7:0]    wdata;
		logic          done;
		logic [15:0]   rdata;
	} tsrb_lk_t;

	tsrb_lk_t s;
	tsrb_lk_t next_s;
	logic     lk_rst;
	logic     ack_s;

	tsrb_sync2 #(.W(2)) u_sync
	(
		.clk_i (lk_clk_i),
		.d_i   ({rst_i, ack_tog_i}),
		.q_o   ({lk_rst, ack_s})
	);

	// ********************************************************
	// Request capture and completion
	// ********************************************************
	// The fields stay frozen until the core acknowledges, which is what
	// makes the multi-bit crossing safe.
	always_comb
	begin
		next_s          = s;
		next_s.done     = 1'b0;
		next_s.ack_prev = ack_s;
		unique case (s.st)
			LK_IDLE:
			begin
				if (req_i)
				begin
					next_s.cmd     = cmd_i;
					next_s.wr      = write_i;
					next_s.word    = word_i;
					next_s.wdata   = wdata_i;
					next_s.req_tog = ~s.req_tog;
					next_s.st      = LK_WAIT;
				end
			end
			LK_WAIT:
			begin
				if (ack_s != s.ack_prev)
				begin
					next_s.rdata = rdata_i;
					next_s.done  = 1'b1;
					next_s.st    = LK_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge lk_clk_i)
	begin
		if (lk_rst)
		begin
			s <= '0;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign busy_o    = (s.st == LK_WAIT);
	assign done_o    = s.done;
	assign rdata_o   = s.rdata;
	assign req_tog_o = s.req_tog;
	assign cmd_o     = s.cmd;
	assign write_o   = s.wr;
	assign word_o    = s.word;
	assign wdata_o   = s.wdata;

endmodule

// ===== test/tsrb_assertions.sv
// Port-level assertions for the thermal register bank.
`timescale 1ns/1ps
module tsrb_assertions
	import tsrb_pkg::*;
(
	input wire logic	mclk_i,
	input wire logic	rst_i,
	input wire logic	lk_clk_i,
	input wire logic	lk_busy_o,
	input wire logic	lk_done_o,
	input wire logic [7:0]	event_i,
	input wire logic [4:0]	lock_i,
	input wire logic	global_interrupt_enable_o,
	input wire logic	shutdown_select_o,
	input wire logic [1:0]	fault_queue_depth_o,
	input wire logic [2:0]	fault_queue_count_o,
	input wire logic [1:0]	remote_resolution_o,
	input wire logic	fault_purge_o,
	input wire logic	conv_restart_o,
	input wire logic	warm_reset_o,
	input wire logic	int_pin_oe_o
);
	// The link side leaves reset two of its own clocks late, so its
	// checks wait three link cycles after the core reset drops.
	logic [1:0] lk_hold;
	always_ff @(posedge lk_clk_i)
	begin
		if (rst_i)
			lk_hold <= 2'h3;
		else if (lk_hold != 2'h0)
			lk_hold <= lk_hold - 2'h1;
	end
	// ****************
	// Checks
	// ****************
	a_count_map: assert property (@(posedge mclk_i) disable iff (rst_i)
		fault_queue_count_o == ((fault_queue_depth_o == 2'h3) ? 3'h6 : 3'h1 << fault_queue_depth_o))
		else $error("fault count does not match depth");
	a_ie_forced: assert property (@(posedge mclk_i) disable iff (rst_i)
		|lock_i[2:0] |-> global_interrupt_enable_o) else $error("enable not forced");
	a_shutdown_select_locked: assert property (@(posedge mclk_i) disable iff (rst_i)
		$past(lock_i[3]) |-> !shutdown_select_o) else $error("shutdown while locked");
	a_shutdown_select_quiet: assert property (@(posedge mclk_i) disable iff (rst_i)
		$rose(shutdown_select_o) |-> ##[0:2] !int_pin_oe_o) else $error("pin held in shutdown");
	a_lock_irq: assert property (@(posedge mclk_i) disable iff (rst_i)
		event_i[0] && lock_i[0] && !shutdown_select_o |=> int_pin_oe_o)
		else $error("locked event gave no interrupt");
	a_restart_pair: assert property (@(posedge mclk_i) disable iff (rst_i)
		conv_restart_o |-> fault_purge_o || $past(fault_purge_o)) else $error("restart without purge");
	a_purge_once: assert property (@(posedge mclk_i) disable iff (rst_i)
		fault_purge_o |=> !fault_purge_o) else $error("purge pulse too long");
	a_warm_defaults: assert property (@(posedge mclk_i) disable iff (rst_i)
		warm_reset_o |-> ##[0:2] (global_interrupt_enable_o && !shutdown_select_o
		&& fault_queue_depth_o == 2'h0 && remote_resolution_o == 2'h0))
		else $error("warm reset left setup changed");
	a_done_pulse: assert property (@(posedge lk_clk_i) disable iff (rst_i || lk_hold != 2'h0)
		lk_done_o |-> !lk_busy_o ##1 !lk_done_o) else $error("done pulse malformed");
	a_busy_bound: assert property (@(posedge lk_clk_i) disable iff (rst_i || lk_hold != 2'h0)
		$rose(lk_busy_o) |-> ##[3:12] lk_done_o) else $error("access never completed");
	c_irq: cover property (@(posedge mclk_i) $rose(int_pin_oe_o));
	c_warm: cover property (@(posedge mclk_i) warm_reset_o);
	c_shutdown_select: cover property (@(posedge mclk_i) $rose(shutdown_select_o));
endmodule
bind tsrb_core tsrb_assertions chk_u (.mclk_i(mclk_i), .rst_i(rst_i), .lk_clk_i(lk_clk_i),
	.lk_busy_o(lk_busy_o), .lk_done_o(lk_done_o), .event_i(event_i), .lock_i(lock_i),
	.global_interrupt_enable_o(global_interrupt_enable_o), .shutdown_select_o(shutdown_select_o),
	.fault_queue_depth_o(fault_queue_depth_o), .fault_queue_count_o(fault_queue_count_o),
	.remote_resolution_o(remote_resolution_o), .fault_purge_o(fault_purge_o),
	.conv_restart_o(conv_restart_o), .warm_reset_o(warm_reset_o), .int_pin_oe_o(int_pin_oe_o));

// ===== test/tsrb_host.sv
// Behavioural link-side host that issues register accesses.
`timescale 1ns/1ps
module tsrb_host
(
	input  wire logic		lk_clk_i,
	input  wire logic		done_i,
	input  wire logic [15:0]	rdata_i,
	output logic			req_o,
	output logic [7:0]		cmd_o,
	output logic			write_o,
	output logic			word_o,
	output logic [7:0]		wdata_o
);
	initial
	begin
		req_o = 1'b0;
		cmd_o = 8'h00;
		write_o = 1'b0;
		word_o = 1'b0;
		wdata_o = 8'h00;
	end
	// ****************
	// Access
	// ****************
	// Request lasts one cycle so it is not taken again after done.
	task automatic xfer(input logic wr, input logic wd, input logic [7:0] c,
		input logic [7:0] d, output logic [15:0] r);
		int n;
		@(posedge lk_clk_i);
		req_o <= 1'b1;
		cmd_o <= c;
		write_o <= wr;
		word_o <= wd & ~wr & (c == 8'h01);
		wdata_o <= (c == 8'h03) ? (d & 8'hFD) : d;
		@(posedge lk_clk_i);
		req_o <= 1'b0;
		n = 0;
		r = 16'hXXXX;
		while (done_i !== 1'b1 && n < 40)
		begin
			@(posedge lk_clk_i);
			n++;
		end
		if (n < 40)
			r = rdata_i;
	endtask
endmodule

// ===== test/tb_top.sv
// Self-checking bench for the thermal register bank.
`timescale 1ns/1ps
module tb_top;
	import tsrb_pkg::*;
	logic mclk_i, rst_i, lk_clk_i, req, wr, wd, busy, done, cd, ie, shutdown_select;
	logic purge, restart, warm, ipin, ioe;
	logic [7:0] cmd, wdata, lt, rh, rl, ev;
	logic [15:0] rdata;
	logic [4:0] lock;
	logic [2:0] fqc;
	logic [1:0] fqd, res;
	int miscompares = 0;
	int total_checks = 0;
	int pulses = 0;
	int warms = 0;
	int n;
	logic [7:0] rst_tab [6] = '{RST_RESULT, RST_RESULT, RST_FLAGS, RST_SETUP, RST_MASK, 8'h00};
	logic [2:0] cnt_tab [4] = '{3'h1, 3'h2, 3'h4, 3'h6};

	tsrb_core dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .lk_clk_i(lk_clk_i), .lk_req_i(req),
		.lk_cmd_i(cmd), .lk_write_i(wr), .lk_word_i(wd), .lk_wdata_i(wdata),
		.lk_busy_o(busy), .lk_done_o(done), .lk_rdata_o(rdata), .conv_done_i(cd),
		.local_temp_i(lt), .remote_high_i(rh), .remote_low_i(rl), .event_i(ev),
		.lock_i(lock), .global_interrupt_enable_o(ie), .shutdown_select_o(shutdown_select),
		.fault_queue_depth_o(fqd), .fault_queue_count_o(fqc), .remote_resolution_o(res),
		.fault_purge_o(purge), .conv_restart_o(restart), .warm_reset_o(warm),
		.int_pin_o(ipin), .int_pin_oe_o(ioe));
	tsrb_host host_u (.lk_clk_i(lk_clk_i), .done_i(done), .rdata_i(rdata), .req_o(req),
		.cmd_o(cmd), .write_o(wr), .word_o(wd), .wdata_o(wdata));

	initial
	begin
		mclk_i = 1'b0;
		forever #2.5 mclk_i = ~mclk_i;
	end
	// The link clock starts off phase, so its rising edges fall a fixed 0.5 ns before core clock edges.
	initial
	begin
		lk_clk_i = 1'b0;
		#7;
		forever #15 lk_clk_i = ~lk_clk_i;
	end
	always @(posedge mclk_i)
	begin
		pulses <= pulses + int'(purge === 1'b1) + int'(restart === 1'b1);
		warms <= warms + int'(warm === 1'b1);
	end

	// ****************
	// Tasks
	// ****************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] c, input logic w, input logic [15:0] e);
		logic [15:0] r;
		host_u.xfer(1'b0, w, c, 8'h00, r);
		chk(r, e);
	endtask
	task automatic wrt(input logic [7:0] c, input logic [7:0] d);
		logic [15:0] r;
		host_u.xfer(1'b1, 1'b0, c, d, r);
	endtask
	task automatic pulse(input logic [7:0] e);
		@(posedge mclk_i);
		ev <= e;
		@(posedge mclk_i);
		ev <= 8'h00;
		repeat (3) @(posedge mclk_i);
	endtask
	task automatic complete_run;
		if (miscompares == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge mclk_i);
		miscompares++;
		complete_run;
	end

	// ****************
	// Tests
	// ****************
	initial
	begin
		rst_i = 1'b1;
		{cd, lt, rh, rl, ev, lock} = '0;
		repeat (8) @(posedge mclk_i);
		rst_i <= 1'b0;
		repeat (6) @(posedge lk_clk_i);
		for (int i = 0; i < 6; i++)
			rd(i[7:0], 1'b0, {rst_tab[i], 8'h00});
		for (int i = 0; i < 3; i++)
		begin
			wrt(i[7:0], 8'hFF);
			rd(i[7:0], 1'b0, 16'h0000);
		end
		@(posedge mclk_i);
		{lt, rh, rl, cd} <= {8'hE7, 8'h55, 8'hA0, 1'b1};
		@(posedge mclk_i);
		{lt, rh, rl, cd} <= {8'h11, 8'h22, 8'h33, 1'b0};
		rd(CMD_LOCAL, 1'b0, 16'hE700);
		rd(CMD_RHIGH, 1'b0, 16'h5500);
		rd(CMD_RHIGH, 1'b1, 16'h55A0);
		pulse(8'h40);
		chk(ioe, 1'b0);
		pulse(8'h04);
		chk(ioe, 1'b1);
		chk(ipin, 1'b0);
		rd(CMD_MASK, 1'b0, 16'h0300);
		pulse(8'h80);
		rd(CMD_FLAGS, 1'b0, 16'hC400);
		chk(ioe, 1'b0);
		rd(CMD_FLAGS, 1'b0, 16'h0000);
		for (int k = 0; k < 4; k++)
		begin
			n = pulses;
			wrt(CMD_SETUP, {2'b10, k[1:0], k[1:0], 2'b00});
			rd(CMD_SETUP, 1'b0, {2'b10, k[1:0], k[1:0], 10'h000});
			chk(fqd, k[1:0]);
			chk(fqc, cnt_tab[k]);
			chk(res, k[1:0]);
			chk(16'(pulses - n), 16'h0002);
		end
		wrt(CMD_SETUP, 8'h80);
		pulse(8'h01);
		chk(ioe, 1'b1);
		wrt(CMD_SETUP, 8'hC0);
		chk(shutdown_select, 1'b1);
		chk(ioe, 1'b0);
		rd(CMD_FLAGS, 1'b0, 16'h0000);
		rd(CMD_LOCAL, 1'b0, 16'hE700);
		wrt(CMD_SETUP, 8'h00);
		pulse(8'h01);
		chk(ioe, 1'b0);
		rd(CMD_FLAGS, 1'b0, 16'h0100);
		@(posedge mclk_i);
		lock <= 5'h01;
		repeat (2) @(posedge mclk_i);
		chk(ie, 1'b1);
		rd(CMD_SETUP, 1'b0, 16'h8000);
		pulse(8'h01);
		chk(ioe, 1'b1);
		rd(CMD_FLAGS, 1'b0, 16'h0100);
		@(posedge mclk_i);
		lock <= 5'h19;
		wrt(CMD_SETUP, 8'hC1);
		chk(shutdown_select, 1'b0);
		rd(CMD_SETUP, 1'b0, 16'h8000);
		chk(16'(warms), 16'h0000);
		@(posedge mclk_i);
		lock <= 5'h00;
		wrt(CMD_MASK, 8'hF0);
		rd(CMD_MASK, 1'b0, 16'hF000);
		wrt(CMD_SETUP, 8'h01);
		chk(16'(warms), 16'h0001);
		rd(CMD_MASK, 1'b0, 16'h0700);
		rd(CMD_LOCAL, 1'b0, 16'h0000);
		complete_run;
	end
endmodule
